// *** core/slc_serial_link_tx_control.sv ***
// Control register bank of the serial link transmitter with sync source and lane logic.
//
// Notes on behaviour
// - Multiframe length is an 8-bit field holding frames per multiframe minus one.
// - The multiframe length field resets to 31, that is 32 frames.
// - In 64B/66B modes the multiframe length is 256*E/F, field ignored.
// - Soft sync bit at 0 requests resync like asserted SYNC~; resets to 1.
// - The soft sync bit acts whatever sync source is selected.
// - A stuck-low sync pin is escaped by selecting source 2 or 3, which both ignore the pins.
// - Source 0 single-ended input, 1 timestamp pair, 2 no pin.
// - Upper lane select 0 drives lanes 0..L-1, 1 drives 4..4+L-1.
// - Sample format 0 offset binary, 1 two's complement; resets to 1.
// - Scrambler enable switches the 8B/10B scrambler; resets to enabled.
// - 64B/66B modes always scramble and ignore the scrambler enable.
// - Link disabled holds link and multiframe counter in reset, serializers off.
// - A 6-bit output mode field selects lanes, encoding and framing.
//
// Local design decision: the strobed register port.
`default_nettype none

module slc_serial_link_tx_control
	import slc_pkg::*;
#(
	parameter int NUM_LANES = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic [slc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [slc_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	output logic [slc_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_single_ended_resync_input_n,
	input wire logic i_timestamp_input_pair_n,
	input wire logic i_timestamp_receiver_enable,
	input wire logic i_sysref,
	input wire logic i_frame_tick,
	output logic o_serial_link_enable,
	output logic o_link_reset_n,
	output logic o_serializer_power_down,
	output logic o_serializer_clock_enable,
	output logic o_sysref_align_enable,
	output logic [slc_pkg::MODE_W-1:0] o_output_mode_select,
	output logic o_is_64b66b,
	output logic [slc_pkg::LANE_CNT_W-1:0] o_lane_count,
	output logic [NUM_LANES-1:0] o_lane_enable,
	output logic o_sample_number_format,
	output logic o_scrambler_active,
	output logic [slc_pkg::K_W-1:0] o_multiframe_length_m1,
	output logic [slc_pkg::K_W-1:0] o_multiframe_count,
	output logic o_multiframe_start,
	output logic o_resync_request_n
);

	import slc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic serial_link_enable;
		logic [MODE_W-1:0] output_mode_select;
		logic [MF_W-1:0] multiframe_length_field;
		logic soft_resync_request_n;
		logic upper_lane_select;
		slc_sync_src_e sync_source;
		logic sample_number_format;
		logic scrambler_enable;
		logic [DATA_W-1:0] rdata;
		logic link_en_q;
		logic link_rst_n_q;
		logic serdes_pd_q;
		logic serdes_clk_en_q;
		logic sysref_align_q;
		logic [MODE_W-1:0] mode_q;
		logic is_64b_q;
		logic [LANE_CNT_W-1:0] lane_cnt_q;
		logic [NUM_LANES-1:0] lane_en_q;
		logic fmt_q;
		logic scr_act_q;
		logic [K_W-1:0] mf_len_m1_q;
		logic [K_W-1:0] mf_cnt;
		logic mf_start_q;
		logic resync_n_q;
		logic sysref_prev;
	} slc_state_s;

	slc_state_s st_reg;
	slc_state_s st_next;

	// ----------------------------------------------------------------
	// Reset and pin synchronisers
	// ----------------------------------------------------------------
	logic rst_n_sync;
	logic [2:0] pins_sync;
	logic single_n_s;
	logic tstamp_n_s;
	logic sysref_s;

	slc_sync2 #(
		.W(1),
		.RST_VAL(1'b0)
	) u_rst_sync (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_d(1'b1),
		.o_q(rst_n_sync)
	);

	// Sync inputs idle high so a fresh link does not see a false request.
	slc_sync2 #(
		.W(3),
		.RST_VAL(3'b011)
	) u_pin_sync (
		.i_sys_clk(i_sys_clk),
		.i_rstn(rst_n_sync),
		.i_d({i_sysref, i_timestamp_input_pair_n, i_single_ended_resync_input_n}),
		.o_q(pins_sync)
	);

	assign single_n_s = pins_sync[0];
	assign tstamp_n_s = pins_sync[1];
	assign sysref_s = pins_sync[2];

	// ----------------------------------------------------------------
	// Output mode lookup
	// ----------------------------------------------------------------
	logic mode_is_64b;
	logic [LANE_CNT_W-1:0] mode_lanes;
	logic [K_W-1:0] mode_mf_64b_m1;

	slc_mode_decode u_mode_decode (
		.i_mode(st_reg.output_mode_select),
		.o_is_64b(mode_is_64b),
		.o_lane_count(mode_lanes),
		.o_mf_64b_m1(mode_mf_64b_m1)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
		addr_hit = (a == b);
	endfunction

	function automatic logic [NUM_LANES-1:0] lane_mask(
		input logic [LANE_CNT_W-1:0] count,
		input logic upper
	);
		logic [LANE_CNT_W:0] base;
		lane_mask = '0;
		base = upper ? {1'b0, UPPER_LANE_BASE} : '0;
		for (int i = 0; i < NUM_LANES; i++) begin
			if ((LANE_CNT_W + 1)'(i) >= base && (LANE_CNT_W + 1)'(i) < base + {1'b0, count}) begin
				lane_mask[i] = 1'b1;
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic pin_level_n;
	logic [K_W-1:0] mf_m1_eff;
	logic sysref_rise;

	always_comb begin
		st_next = st_reg;
		pin_level_n = 1'b1;
		mf_m1_eff = '0;
		sysref_rise = 1'b0;

		// Register writes; reserved bits are not stored and read back as zero.
		if (i_we) begin
			if (addr_hit(i_addr, LINK_ENABLE_ADDR)) begin
				st_next.serial_link_enable = i_wdata[LINK_EN_BIT];
			end
			if (addr_hit(i_addr, OUTPUT_MODE_ADDR)) begin
				st_next.output_mode_select = i_wdata[MODE_W-1:0];
			end
			if (addr_hit(i_addr, MF_LENGTH_ADDR)) begin
				st_next.multiframe_length_field = i_wdata[MF_W-1:0];
			end
			if (addr_hit(i_addr, SOFT_SYNC_ADDR)) begin
				st_next.soft_resync_request_n = i_wdata[SOFT_SYNC_BIT];
			end
			if (addr_hit(i_addr, LINK_CTRL_ADDR)) begin
				st_next.upper_lane_select = i_wdata[CTRL_UPPER_BIT];
				st_next.sync_source = slc_sync_src_e'(i_wdata[CTRL_SEL_MSB:CTRL_SEL_LSB]);
				st_next.sample_number_format = i_wdata[CTRL_FMT_BIT];
				st_next.scrambler_enable = i_wdata[CTRL_SCR_BIT];
			end
		end

		// Read data stands for the one cycle after the strobe only.
		st_next.rdata = '0;
		if (i_re) begin
			if (addr_hit(i_addr, LINK_ENABLE_ADDR)) begin
				st_next.rdata[LINK_EN_BIT] = st_reg.serial_link_enable;
			end
			if (addr_hit(i_addr, OUTPUT_MODE_ADDR)) begin
				st_next.rdata[MODE_W-1:0] = st_reg.output_mode_select;
			end
			if (addr_hit(i_addr, MF_LENGTH_ADDR)) begin
				st_next.rdata[MF_W-1:0] = st_reg.multiframe_length_field;
			end
			if (addr_hit(i_addr, SOFT_SYNC_ADDR)) begin
				st_next.rdata[SOFT_SYNC_BIT] = st_reg.soft_resync_request_n;
			end
			if (addr_hit(i_addr, LINK_CTRL_ADDR)) begin
				st_next.rdata[CTRL_UPPER_BIT] = st_reg.upper_lane_select;
				st_next.rdata[CTRL_SEL_MSB:CTRL_SEL_LSB] = st_reg.sync_source;
				st_next.rdata[CTRL_FMT_BIT] = st_reg.sample_number_format;
				st_next.rdata[CTRL_SCR_BIT] = st_reg.scrambler_enable;
			end
		end

		// Sync source; a receiver that is switched off cannot request, so it reads idle.
		unique case (st_reg.sync_source)
			SYNC_SRC_SINGLE: pin_level_n = single_n_s;
			SYNC_SRC_TSTAMP: pin_level_n = tstamp_n_s | ~i_timestamp_receiver_enable;
			SYNC_SRC_NONE: pin_level_n = 1'b1;
			SYNC_SRC_RSVD: pin_level_n = 1'b1;
		endcase
		st_next.resync_n_q = st_reg.soft_resync_request_n & pin_level_n;

		// Multiframe length in effect for the selected encoding.
		if (mode_is_64b) begin
			mf_m1_eff = mode_mf_64b_m1;
		end else begin
			mf_m1_eff = K_W'(st_reg.multiframe_length_field);
		end
		st_next.mf_len_m1_q = mf_m1_eff;

		// Derived link controls.
		st_next.link_en_q = st_reg.serial_link_enable;
		st_next.link_rst_n_q = st_reg.serial_link_enable;
		st_next.serdes_pd_q = ~st_reg.serial_link_enable;
		st_next.serdes_clk_en_q = st_reg.serial_link_enable;
		st_next.sysref_align_q = st_reg.serial_link_enable;
		st_next.mode_q = st_reg.output_mode_select;
		st_next.is_64b_q = mode_is_64b;
		st_next.lane_cnt_q = mode_lanes;
		st_next.fmt_q = st_reg.sample_number_format;
		st_next.scr_act_q = mode_is_64b | st_reg.scrambler_enable;
		if (st_reg.serial_link_enable) begin
			st_next.lane_en_q = lane_mask(mode_lanes, st_reg.upper_lane_select);
		end else begin
			st_next.lane_en_q = '0;
		end

		// Multiframe counter; SYSREF realigns it only while the link runs.
		st_next.sysref_prev = sysref_s;
		sysref_rise = sysref_s & ~st_reg.sysref_prev;
		st_next.mf_start_q = 1'b0;
		if (!st_reg.serial_link_enable) begin
			st_next.mf_cnt = '0;
		end else if (sysref_rise) begin
			st_next.mf_cnt = '0;
			st_next.mf_start_q = 1'b1;
		end else if (i_frame_tick) begin
			if (st_reg.mf_cnt >= mf_m1_eff) begin
				st_next.mf_cnt = '0;
				st_next.mf_start_q = 1'b1;
			end else begin
				st_next.mf_cnt = st_reg.mf_cnt + K_W'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			st_reg.serial_link_enable <= LINK_EN_RST;
			st_reg.output_mode_select <= MODE_RST;
			st_reg.multiframe_length_field <= MF_LENGTH_RST;
			st_reg.soft_resync_request_n <= SOFT_SYNC_RST;
			st_reg.upper_lane_select <= UPPER_RST;
			st_reg.sync_source <= SYNC_SRC_SINGLE;
			st_reg.sample_number_format <= FMT_RST;
			st_reg.scrambler_enable <= SCR_RST;
			st_reg.rdata <= '0;
			st_reg.link_en_q <= 1'b0;
			st_reg.link_rst_n_q <= 1'b0;
			st_reg.serdes_pd_q <= 1'b1;
			st_reg.serdes_clk_en_q <= 1'b0;
			st_reg.sysref_align_q <= 1'b0;
			st_reg.mode_q <= MODE_RST;
			st_reg.is_64b_q <= 1'b0;
			st_reg.lane_cnt_q <= '0;
			st_reg.lane_en_q <= '0;
			st_reg.fmt_q <= FMT_RST;
			st_reg.scr_act_q <= SCR_RST;
			st_reg.mf_len_m1_q <= K_W'(MF_LENGTH_RST);
			st_reg.mf_cnt <= '0;
			st_reg.mf_start_q <= 1'b0;
			st_reg.resync_n_q <= 1'b1;
			st_reg.sysref_prev <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output is a flop; derived controls lag a register write by one extra cycle.
	assign o_rdata = st_reg.rdata;
	assign o_serial_link_enable = st_reg.link_en_q;
	assign o_link_reset_n = st_reg.link_rst_n_q;
	assign o_serializer_power_down = st_reg.serdes_pd_q;
	assign o_serializer_clock_enable = st_reg.serdes_clk_en_q;
	assign o_sysref_align_enable = st_reg.sysref_align_q;
	assign o_output_mode_select = st_reg.mode_q;
	assign o_is_64b66b = st_reg.is_64b_q;
	assign o_lane_count = st_reg.lane_cnt_q;
	assign o_lane_enable = st_reg.lane_en_q;
	assign o_sample_number_format = st_reg.fmt_q;
	assign o_scrambler_active = st_reg.scr_act_q;
	assign o_multiframe_length_m1 = st_reg.mf_len_m1_q;
	assign o_multiframe_count = st_reg.mf_cnt;
	assign o_multiframe_start = st_reg.mf_start_q;
	assign o_resync_request_n = st_reg.resync_n_q;

endmodule

`default_nettype wire

// *** shared/slc_pkg.sv ***
// Package with the register map, field layout and reset values of the serial link control bank.
`default_nettype none

package slc_pkg;

	// ----------------------------------------------------------------
	// Bus widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int MODE_W = 6;
	localparam int MF_W = 8;
	localparam int K_W = 16;
	localparam int LANE_CNT_W = 4;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] LINK_ENABLE_ADDR = 12'h200;
	localparam logic [ADDR_W-1:0] OUTPUT_MODE_ADDR = 12'h201;
	localparam logic [ADDR_W-1:0] MF_LENGTH_ADDR = 12'h202;
	localparam logic [ADDR_W-1:0] SOFT_SYNC_ADDR = 12'h203;
	localparam logic [ADDR_W-1:0] LINK_CTRL_ADDR = 12'h204;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int LINK_EN_BIT = 0;
	localparam int SOFT_SYNC_BIT = 0;
	localparam int CTRL_UPPER_BIT = 4;
	localparam int CTRL_SEL_MSB = 3;
	localparam int CTRL_SEL_LSB = 2;
	localparam int CTRL_FMT_BIT = 1;
	localparam int CTRL_SCR_BIT = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic LINK_EN_RST = 1'h1;
	localparam logic [MODE_W-1:0] MODE_RST = 6'h00;
	localparam logic [MF_W-1:0] MF_LENGTH_RST = 8'h1f;
	localparam logic SOFT_SYNC_RST = 1'h1;
	localparam logic UPPER_RST = 1'h0;
	localparam logic FMT_RST = 1'h1;
	localparam logic SCR_RST = 1'h1;

	// ----------------------------------------------------------------
	// Derived constants
	// ----------------------------------------------------------------
	localparam logic [K_W-1:0] MF_64B_SCALE = 16'h0100;
	localparam logic [LANE_CNT_W-1:0] UPPER_LANE_BASE = 4'h4;

	typedef enum logic [1:0] {
		SYNC_SRC_SINGLE = 2'h0,
		SYNC_SRC_TSTAMP = 2'h1,
		SYNC_SRC_NONE = 2'h2,
		SYNC_SRC_RSVD = 2'h3
	} slc_sync_src_e;

endpackage

`default_nettype wire

// *** core/slc_sync2.sv ***
// Two-flop synchroniser with a constant reset value.
`default_nettype none

module slc_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} slc_sync_s;

	slc_sync_s st_reg;
	slc_sync_s st_next;

	// The first stage feeds the second stage only, so metastability never reaches logic.
	always_comb begin
		st_next.s1 = i_d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_reg <= '{s1: RST_VAL, s2: RST_VAL};
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_q = st_reg.s2;

endmodule

`default_nettype wire

// *** core/slc_mode_decode.sv ***
// Lookup of lane count, encoding and 64B/66B multiframe length from the output mode.
`default_nettype none

module slc_mode_decode
	import slc_pkg::*;
#(
	parameter int NUM_MODES = 64,
	parameter logic [NUM_MODES-1:0] IS_64B_TBL = '0,
	parameter logic [NUM_MODES*LANE_CNT_W-1:0] LANES_TBL = {NUM_MODES{4'h4}},
	parameter logic [NUM_MODES*8-1:0] E_TBL = {NUM_MODES{8'h01}},
	parameter logic [NUM_MODES*8-1:0] F_TBL = {NUM_MODES{8'h08}}
) (
	input wire logic [slc_pkg::MODE_W-1:0] i_mode,
	output logic o_is_64b,
	output logic [slc_pkg::LANE_CNT_W-1:0] o_lane_count,
	output logic [slc_pkg::K_W-1:0] o_mf_64b_m1
);

	import slc_pkg::*;

	logic [7:0] e_val;
	logic [7:0] f_val;
	logic [K_W-1:0] k_val;

	// The divider is shared by all modes; in 64B/66B modes its result sets the multiframe counter wrap.
	always_comb begin
		o_is_64b = IS_64B_TBL[i_mode];
		o_lane_count = LANES_TBL[i_mode*LANE_CNT_W +: LANE_CNT_W];
		e_val = E_TBL[i_mode*8 +: 8];
		f_val = F_TBL[i_mode*8 +: 8];
		k_val = K_W'(e_val) * MF_64B_SCALE;
		if (f_val != 8'h00) begin
			k_val = k_val / K_W'(f_val);
		end
		if (k_val == '0) begin
			o_mf_64b_m1 = '0;
		end else begin
			o_mf_64b_m1 = k_val - K_W'(1);
		end
	end

endmodule

`default_nettype wire

// *** bench/slc_tx_ctrl_sva.sv ***
// Concurrent checks on the ports of the serial link control bank.
`default_nettype none

module slc_tx_ctrl_sva
	import slc_pkg::*;
#(
	parameter int NUM_LANES = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic [slc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [slc_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	input wire logic [slc_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_frame_tick,
	input wire logic o_serial_link_enable,
	input wire logic o_link_reset_n,
	input wire logic o_serializer_power_down,
	input wire logic o_serializer_clock_enable,
	input wire logic o_sysref_align_enable,
	input wire logic o_is_64b66b,
	input wire logic [slc_pkg::LANE_CNT_W-1:0] o_lane_count,
	input wire logic [NUM_LANES-1:0] o_lane_enable,
	input wire logic o_scrambler_active,
	input wire logic [slc_pkg::K_W-1:0] o_multiframe_length_m1,
	input wire logic [slc_pkg::K_W-1:0] o_multiframe_count,
	input wire logic o_multiframe_start,
	input wire logic o_resync_request_n
);
	timeunit 1ns;
	timeprecision 1ps;
	import slc_pkg::*;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Lane masks come from the lane count so one check covers both mappings.
	logic [NUM_LANES-1:0] low_mask;
	assign low_mask = NUM_LANES'((16'h0001 << o_lane_count) - 16'h0001);

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_link_off;
		!o_serial_link_enable |-> !o_link_reset_n && o_serializer_power_down && !o_serializer_clock_enable
			&& !o_sysref_align_enable && o_lane_enable == '0;
	endproperty
	a_link_off: assert property (p_link_off) else $error("Link disabled but link logic active.");
	property p_count_off;
		!o_serial_link_enable && !$past(o_serial_link_enable) |-> o_multiframe_count == 16'h0000;
	endproperty
	a_count_off: assert property (p_count_off) else $error("Counter not held while disabled.");
	property p_scr64;
		o_is_64b66b |-> o_scrambler_active;
	endproperty
	a_scr64: assert property (p_scr64) else $error("Wide-block mode without scrambling.");
	property p_lanes;
		o_serial_link_enable |-> o_lane_enable == low_mask || o_lane_enable == (low_mask << 4);
	endproperty
	a_lanes: assert property (p_lanes) else $error("Lane enables match neither mapping.");
	property p_start;
		o_multiframe_start |-> o_multiframe_count == 16'h0000;
	endproperty
	a_start: assert property (p_start) else $error("Multiframe start with nonzero count.");
	property p_tick;
		i_frame_tick && o_serial_link_enable |=> !o_serial_link_enable || o_multiframe_start
			|| o_multiframe_count == $past(o_multiframe_count) + 16'h0001;
	endproperty
	a_tick: assert property (p_tick) else $error("Frame tick did not advance the counter.");
	property p_hold;
		!i_frame_tick |=> o_multiframe_start || o_multiframe_count == 16'h0000 || $stable(o_multiframe_count);
	endproperty
	a_hold: assert property (p_hold) else $error("Counter moved without a frame tick.");
	property p_soft;
		i_we && i_addr == SOFT_SYNC_ADDR && !i_wdata[SOFT_SYNC_BIT] |-> ##2 !o_resync_request_n;
	endproperty
	a_soft: assert property (p_soft) else $error("Soft request did not reach the output.");
	property p_rsvd;
		i_re && i_addr == SOFT_SYNC_ADDR |=> o_rdata[7:1] == 7'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("Reserved bits read nonzero.");
	property p_mf8;
		!o_is_64b66b |-> o_multiframe_length_m1[15:8] == 8'h00;
	endproperty
	a_mf8: assert property (p_mf8) else $error("Frame-based length exceeds eight bits.");

	c_soft: cover property (!o_resync_request_n);
	c_start: cover property (o_multiframe_start);
	c_upper: cover property (o_serial_link_enable && o_lane_enable[NUM_LANES-1]);
endmodule

bind slc_serial_link_tx_control slc_tx_ctrl_sva #(.NUM_LANES(NUM_LANES)) u_sva (
	.i_sys_clk, .i_rstn, .i_addr, .i_wdata, .i_we, .i_re, .o_rdata, .i_frame_tick,
	.o_serial_link_enable, .o_link_reset_n, .o_serializer_power_down, .o_serializer_clock_enable,
	.o_sysref_align_enable, .o_is_64b66b, .o_lane_count, .o_lane_enable, .o_scrambler_active,
	.o_multiframe_length_m1, .o_multiframe_count, .o_multiframe_start, .o_resync_request_n
);

`default_nettype wire

// *** bench/slc_rx_model.sv ***
// Behavioural far-end receiver that drives the resync request lines.
`default_nettype none

module slc_rx_model (
	input wire logic i_sys_clk,
	input wire logic i_want_sync,
	input wire logic i_stuck_low,
	input wire logic i_use_pair,
	output logic o_sync_se_n,
	output logic o_sync_pair_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic req_n;
	// A stuck-low line keeps the request asserted whatever the receiver wants.
	assign req_n = !(i_want_sync || i_stuck_low);
	// The line not in use idles at its pull-up level, so a stale low never lingers.
	always @(posedge i_sys_clk) begin
		o_sync_se_n <= i_use_pair ? 1'b1 : req_n;
		o_sync_pair_n <= i_use_pair ? req_n : 1'b1;
	end
endmodule

`default_nettype wire

// *** bench/tb_serial_link_tx_control.sv ***
// Self-checking bench for the serial link control bank.
`default_nettype none

`define CHK(nm, ex, got) begin \
	check_count++; \
	if ((got) !== (ex)) begin \
		bad_count++; \
		$display("BAD %s expected %h seen %h", nm, ex, got); \
	end \
end

module tb_serial_link_tx_control
	import slc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [DATA_W-1:0] i_wdata = '0;
	logic i_we = 1'b0;
	logic i_re = 1'b0;
	logic i_timestamp_receiver_enable = 1'b0;
	logic i_sysref = 1'b0;
	logic i_frame_tick = 1'b0;
	logic want_sync = 1'b0;
	logic stuck_low = 1'b0;
	logic use_pair = 1'b0;
	logic i_single_ended_resync_input_n, i_timestamp_input_pair_n;
	logic [DATA_W-1:0] o_rdata;
	logic o_serial_link_enable, o_link_reset_n, o_serializer_power_down, o_serializer_clock_enable;
	logic o_sysref_align_enable, o_is_64b66b, o_sample_number_format, o_scrambler_active;
	logic o_multiframe_start, o_resync_request_n;
	logic [MODE_W-1:0] o_output_mode_select;
	logic [LANE_CNT_W-1:0] o_lane_count;
	logic [7:0] o_lane_enable;
	logic [K_W-1:0] o_multiframe_length_m1, o_multiframe_count;
	int bad_count = 0;
	int check_count = 0;

	typedef struct {
		logic we;
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
		logic [DATA_W-1:0] e;
	} slc_row_s;
	slc_row_s rows [9] = '{
		'{1'b0, MF_LENGTH_ADDR, 8'h00, 8'h1f},
		'{1'b0, SOFT_SYNC_ADDR, 8'h00, 8'h01},
		'{1'b0, LINK_CTRL_ADDR, 8'h00, 8'h03},
		'{1'b1, LINK_ENABLE_ADDR, 8'h00, 8'h00},
		'{1'b1, MF_LENGTH_ADDR, 8'h05, 8'h05},
		'{1'b1, SOFT_SYNC_ADDR, 8'h00, 8'h00},
		'{1'b1, LINK_CTRL_ADDR, 8'h1f, 8'h1f},
		'{1'b1, 12'h2ff, 8'haa, 8'h00},
		'{1'b1, OUTPUT_MODE_ADDR, 8'h03, 8'h03}
	};

	slc_serial_link_tx_control #(.NUM_LANES(8)) u_dut (
		.i_sys_clk, .i_rstn, .i_addr, .i_wdata, .i_we, .i_re, .o_rdata,
		.i_single_ended_resync_input_n, .i_timestamp_input_pair_n, .i_timestamp_receiver_enable,
		.i_sysref, .i_frame_tick, .o_serial_link_enable, .o_link_reset_n, .o_serializer_power_down,
		.o_serializer_clock_enable, .o_sysref_align_enable, .o_output_mode_select, .o_is_64b66b,
		.o_lane_count, .o_lane_enable, .o_sample_number_format, .o_scrambler_active,
		.o_multiframe_length_m1, .o_multiframe_count, .o_multiframe_start, .o_resync_request_n
	);
	slc_rx_model u_rx (
		.i_sys_clk(i_sys_clk),
		.i_want_sync(want_sync),
		.i_stuck_low(stuck_low),
		.i_use_pair(use_pair),
		.o_sync_se_n(i_single_ended_resync_input_n),
		.o_sync_pair_n(i_timestamp_input_pair_n)
	);

	initial begin
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	// ----------------------------------------------------------------
	// Bus and timing tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_sys_clk);
		i_we <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_we <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
		@(posedge i_sys_clk);
		i_re <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_re <= 1'b0;
		#1;
		q = o_rdata;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic tick();
		@(posedge i_sys_clk);
		i_frame_tick <= 1'b1;
		@(posedge i_sys_clk);
		i_frame_tick <= 1'b0;
		#1;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		logic [DATA_W-1:0] q;
		repeat (16) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		cyc(3);
		`CHK("format", 1'b1, o_sample_number_format)
		`CHK("scrambler", 1'b1, o_scrambler_active)
		foreach (rows[i]) begin
			if (rows[i].we) begin
				wr(rows[i].a, rows[i].d);
			end
			rd(rows[i].a, q);
			`CHK("register", rows[i].e, q)
		end
		tick();
		`CHK("link reset", 1'b0, o_link_reset_n)
		`CHK("power down", 1'b1, o_serializer_power_down)
		`CHK("lanes off", 8'h00, o_lane_enable)
		`CHK("count held", 16'h0000, o_multiframe_count)
		`CHK("mode", 6'h03, o_output_mode_select)
		`CHK("soft request", 1'b0, o_resync_request_n)
		$display("test registers done");
		wr(SOFT_SYNC_ADDR, 8'h01);
		wr(LINK_CTRL_ADDR, 8'h03);
		@(posedge i_sys_clk);
		stuck_low <= 1'b1;
		cyc(5);
		`CHK("pin request", 1'b0, o_resync_request_n)
		wr(LINK_CTRL_ADDR, 8'h0b);
		cyc(2);
		`CHK("pin ignored", 1'b1, o_resync_request_n)
		wr(SOFT_SYNC_ADDR, 8'h00);
		cyc(2);
		`CHK("soft only", 1'b0, o_resync_request_n)
		wr(SOFT_SYNC_ADDR, 8'h01);
		@(posedge i_sys_clk);
		stuck_low <= 1'b0;
		use_pair <= 1'b1;
		want_sync <= 1'b1;
		i_timestamp_receiver_enable <= 1'b1;
		wr(LINK_CTRL_ADDR, 8'h07);
		cyc(5);
		`CHK("pair request", 1'b0, o_resync_request_n)
		@(posedge i_sys_clk);
		want_sync <= 1'b0;
		cyc(5);
		`CHK("pair released", 1'b1, o_resync_request_n)
		$display("test sync done");
		wr(LINK_CTRL_ADDR, 8'h03);
		wr(LINK_ENABLE_ADDR, 8'h01);
		cyc(2);
		`CHK("lower lanes", 8'h0f, o_lane_enable)
		`CHK("link running", 1'b1, o_link_reset_n)
		wr(LINK_ENABLE_ADDR, 8'h00);
		wr(LINK_CTRL_ADDR, 8'h10);
		wr(LINK_ENABLE_ADDR, 8'h01);
		cyc(2);
		`CHK("upper lanes", 8'hf0, o_lane_enable)
		`CHK("offset binary", 1'b0, o_sample_number_format)
		`CHK("scrambler off", 1'b0, o_scrambler_active)
		$display("test lanes done");
		wr(LINK_ENABLE_ADDR, 8'h00);
		wr(MF_LENGTH_ADDR, 8'h02);
		wr(LINK_CTRL_ADDR, 8'h03);
		wr(LINK_ENABLE_ADDR, 8'h01);
		cyc(2);
		`CHK("length", 16'h0002, o_multiframe_length_m1)
		for (int i = 1; i <= 4; i++) begin
			tick();
			`CHK("count", 16'(i % 3), o_multiframe_count)
			`CHK("start", 1'(i % 3 == 0), o_multiframe_start)
		end
		@(posedge i_sys_clk);
		i_sysref <= 1'b1;
		for (int k = 0; k < 8 && o_multiframe_start !== 1'b1; k++) begin
			cyc(1);
		end
		`CHK("realign start", 1'b1, o_multiframe_start)
		`CHK("realign count", 16'h0000, o_multiframe_count)
		@(posedge i_sys_clk);
		i_sysref <= 1'b0;
		wr(LINK_ENABLE_ADDR, 8'h00);
		@(posedge i_sys_clk);
		i_sysref <= 1'b1;
		cyc(3);
		`CHK("ignored start", 1'b0, o_multiframe_start)
		`CHK("ignored count", 16'h0000, o_multiframe_count)
		@(posedge i_sys_clk);
		i_sysref <= 1'b0;
		$display("test multiframe done");
		give_verdict();
	end

	// The whole run needs well under a thousand cycles.
	initial begin
		#50us;
		bad_count++;
		$display("watchdog expired");
		give_verdict();
	end
endmodule

`default_nettype wire
